// ### hw/shift_reg_pkg.sv
// constants shared by the shift register block and its cells
package shift_reg_pkg;

	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int unsigned NUM_REGS = 4;
	localparam int unsigned REG_BITS = 8;
	localparam int unsigned SEL_W = 3;

	// ---------------------------------------------------------------
	// scan cycle timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned SCAN_TIME_NS = 1000;
	localparam int unsigned SCAN_CYCLES =
		(SCAN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SCAN_CNT_W = 12;

	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] CFG0_OFS = 8'h00;
	localparam logic [7:0] CFG_STRIDE = 8'h04;
	localparam logic [7:0] CONTENTS_OFS = 8'h10;
	localparam logic [7:0] CTRL_OFS = 8'h14;
	localparam int unsigned ADDR_W = 8;

	// cfg fields
	localparam int unsigned CFG_SEL_LSB = 0;
	localparam int unsigned CFG_RETAIN_BIT = 8;
	// ctrl fields
	localparam int unsigned CTRL_RUN_BIT = 0;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
	localparam logic [NUM_REGS-1:0] RETAIN_RESET = 4'h0;
	localparam logic RUN_RESET = 1'b1;
	localparam logic [31:0] HRDATA_RESET = 32'h0000_0000;

	// ahb encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;
	localparam logic HRESP_OKAY = 1'b0;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [REG_BITS-1:0] shift_step(
		input logic [REG_BITS-1:0] cur,
		input logic din,
		input logic down
	);
		logic [REG_BITS-1:0] nxt;
		nxt = down ? {din, cur[REG_BITS-1:1]} : {cur[REG_BITS-2:0], din};
		return nxt;
	endfunction : shift_step

endpackage : shift_reg_pkg

// ### hw/shift_cell.sv
// one eight-bit edge-triggered shift register with bit select output
module shift_cell
	import shift_reg_pkg::*;
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// scan timing and control
	input wire logic scan_en,
	input wire logic clear,
	input wire logic [shift_reg_pkg::SEL_W-1:0] sel,
	// function block inputs
	input wire logic trg,
	input wire logic din,
	input wire logic dir,
	// results
	output logic [shift_reg_pkg::REG_BITS-1:0] bits,
	output logic q
);

	logic trg_prev_q;
	logic [REG_BITS-1:0] bits_q;
	logic [REG_BITS-1:0] bits_d;
	logic q_q;
	wire rise = trg & ~trg_prev_q;

	// ---------------------------------------------------------------
	// next contents
	// ---------------------------------------------------------------
	assign bits_d = clear ? '0 :
		(scan_en & rise) ? shift_step(bits_q, din, dir) :
		bits_q;

	// ---------------------------------------------------------------
	// edge memory from previous scan
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			trg_prev_q <= 1'b0;
		else if (scan_en)
			trg_prev_q <= trg;
	end

	// contents carry no reset so a retentive register survives it
	always_ff @(posedge hclk)
	begin
		bits_q <= bits_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q_q <= 1'b0;
		else
			q_q <= bits_d[sel];
	end

	assign bits = bits_q;
	assign q = q_q;

endmodule : shift_cell

// ### hw/shift_reg_block.sv
// four edge-triggered shift registers with an ahb-lite register file
//
// Contract
// - rising trigger edge samples data and shifts exactly once
// - falling trigger edge changes neither contents nor output
// - direction low: bit 1 takes data, bits move toward bit 8
// - direction high: bit 8 takes data, bits move toward bit 1
// - output q always shows one configured bit, bit 1 to 8
// - four independent registers, each bit addressable by index and position
// - retentive register keeps its contents across power loss; code keeps it across hresetn only if set in RETAIN_DEFAULT
// - non-retentive register restarts from its initial state; code clears it at reset only if its RETAIN_DEFAULT bit is 0
module shift_reg_block
	import shift_reg_pkg::*;
#(
	parameter int unsigned SCAN_DIV = shift_reg_pkg::SCAN_CYCLES,
	parameter logic [shift_reg_pkg::NUM_REGS-1:0] RETAIN_DEFAULT =
		shift_reg_pkg::RETAIN_RESET
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// function block inputs, one bit per register index
	input wire logic [shift_reg_pkg::NUM_REGS-1:0] trg,
	input wire logic [shift_reg_pkg::NUM_REGS-1:0] din,
	input wire logic [shift_reg_pkg::NUM_REGS-1:0] dir,
	// function block outputs
	output logic [shift_reg_pkg::NUM_REGS-1:0] q
);
	import shift_reg_pkg::*;

	// ---------------------------------------------------------------
	// elaboration checks
	// ---------------------------------------------------------------
	if (SCAN_DIV < 1 || SCAN_DIV >= (1 << SCAN_CNT_W))
	begin : g_bad_div
		$error("scan divider out of range");
	end

	if (NUM_REGS * REG_BITS > 32)
	begin : g_bad_width
		$error("register contents exceed one bus word");
	end

	if (NUM_REGS > 4)
	begin : g_bad_count
		$error("register index decode is two bits wide");
	end

	if ((1 << SEL_W) != REG_BITS)
	begin : g_bad_sel
		$error("bit select width does not match register length");
	end

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [SCAN_CNT_W-1:0] scan_cnt_q;
	logic [SCAN_CNT_W-1:0] scan_cnt_d;
	logic scan_en_q;
	logic init_q;
	logic run_q;
	logic [SEL_W-1:0] sel_q [NUM_REGS];
	logic [NUM_REGS-1:0] retain_q;
	logic wr_pend_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic [NUM_REGS*REG_BITS-1:0] contents;

	// ---------------------------------------------------------------
	// scan divider
	// ---------------------------------------------------------------
	localparam logic [SCAN_CNT_W-1:0] SCAN_LAST = SCAN_CNT_W'(SCAN_DIV - 1);
	wire scan_wrap = (scan_cnt_q == SCAN_LAST);
	assign scan_cnt_d = scan_wrap ? '0 : scan_cnt_q + 1'b1;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			scan_cnt_q <= '0;
		else
			scan_cnt_q <= scan_cnt_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			scan_en_q <= 1'b0;
		else
			scan_en_q <= scan_wrap & run_q & ~init_q;
	end

	// first cycle after reset release clears the non-retentive registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			init_q <= 1'b1;
		else
			init_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// address decode helpers
	// ---------------------------------------------------------------
	function automatic logic cfg_hit(input logic [ADDR_W-1:0] ofs);
		return (ofs < CONTENTS_OFS) && (ofs[1:0] == 2'b00);
	endfunction : cfg_hit

	function automatic logic [1:0] cfg_index(input logic [ADDR_W-1:0] ofs);
		return ofs[3:2];
	endfunction : cfg_index

	// ---------------------------------------------------------------
	// ahb-lite decode
	// ---------------------------------------------------------------
	wire addr_phase = hsel & hready & htrans[1];
	wire [ADDR_W-1:0] a_ofs = haddr[ADDR_W-1:0];
	wire a_cfg = cfg_hit(a_ofs);
	wire [1:0] a_idx = cfg_index(a_ofs);
	wire w_cfg = cfg_hit(wr_addr_q);
	wire [1:0] w_idx = cfg_index(wr_addr_q);
	wire w_ctrl = (wr_addr_q == CTRL_OFS);

	logic [31:0] rd_word;
	always_comb
	begin
		rd_word = '0;
		if (a_cfg)
		begin
			rd_word[CFG_SEL_LSB +: SEL_W] = sel_q[a_idx];
			rd_word[CFG_RETAIN_BIT] = retain_q[a_idx];
		end
		else if (a_ofs == CONTENTS_OFS)
			rd_word = contents;
		else if (a_ofs == CTRL_OFS)
			rd_word[CTRL_RUN_BIT] = run_q;
	end

	// ---------------------------------------------------------------
	// ahb-lite data phase
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
		end
		else if (hready)
		begin
			wr_pend_q <= addr_phase & hwrite;
			wr_addr_q <= a_ofs;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= HRDATA_RESET;
		else if (addr_phase & ~hwrite)
			hrdata_q <= rd_word;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hreadyout_q <= 1'b1;
		else
			hreadyout_q <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hresp_q <= HRESP_OKAY;
		else
			hresp_q <= HRESP_OKAY;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			run_q <= RUN_RESET;
		else if (wr_pend_q & w_ctrl)
			run_q <= hwdata[CTRL_RUN_BIT];
	end

	// ---------------------------------------------------------------
	// per-register configuration and cells
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NUM_REGS; i++)
	begin : g_reg
		wire cfg_wr = wr_pend_q & w_cfg & (w_idx == 2'(i));

		always_ff @(posedge hclk or negedge hresetn)
		begin
			if (!hresetn)
			begin
				sel_q[i] <= SEL_RESET;
				retain_q[i] <= RETAIN_DEFAULT[i];
			end
			else if (cfg_wr)
			begin
				sel_q[i] <= hwdata[CFG_SEL_LSB +: SEL_W];
				retain_q[i] <= hwdata[CFG_RETAIN_BIT];
			end
		end

		shift_cell u_cell (
			.hclk(hclk),
			.hresetn(hresetn),
			.scan_en(scan_en_q),
			.clear(init_q & ~retain_q[i]),
			.sel(sel_q[i]),
			.trg(trg[i]),
			.din(din[i]),
			.dir(dir[i]),
			.bits(contents[i*REG_BITS +: REG_BITS]),
			.q(q[i])
		);
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

endmodule : shift_reg_block

// ### tb/shift_reg_checker.sv
// assertions on the shift register block ports
module shift_reg_checker
	import shift_reg_pkg::*;
(
	// bus
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// function
	input wire logic [shift_reg_pkg::NUM_REGS-1:0] trg,
	input wire logic [shift_reg_pkg::NUM_REGS-1:0] q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] age_q;
	wire req = hsel && hready && htrans[1];
	wire rd_cont = req && !hwrite && haddr[7:0] == CONTENTS_OFS;
	wire quiet = age_q == 3'h7;
	// cycles since the last write or reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			age_q <= 3'h0;
		else if (req && hwrite)
			age_q <= 3'h0;
		else if (!quiet)
			age_q <= age_q + 3'h1;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_BUS_OK: assert property (hreadyout && hresp == HRESP_OKAY)
		else $error("bus not ready or not okay");
	AST_RST_IDLE: assert property (disable iff (1'b0)
		!hresetn |-> q == 4'h0 && hrdata == 32'h0000_0000)
		else $error("outputs not cleared in reset");
	AST_ONLY_HIGH: assert property (quiet |->
		((q ^ $past(q)) & ~$past(trg)) == 4'h0)
		else $error("q moved without trigger high");
	AST_HELD_HIGH: assert property (trg[0] [*8] ##1 (trg[0] && quiet)
		|=> $stable(q[0]))
		else $error("second shift on held trigger");
	AST_HELD_LOW: assert property ((!trg[2]) [*6] ##0 quiet
		|=> $stable(q[2]))
		else $error("shift on low trigger");
	AST_UNMAPPED: assert property (req && !hwrite && haddr[7:0] > CTRL_OFS
		|=> ##1 hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_Q_ZERO: assert property (rd_cont
		|=> ##1 (hrdata[7:0] != 8'h00 || !$past(q[0])))
		else $error("q set from empty register");
	AST_Q_ONE: assert property (rd_cont
		|=> ##1 (hrdata[15:8] != 8'hff || $past(q[1])))
		else $error("q clear from full register");
endmodule : shift_reg_checker

// ### tb/fb_model.sv
// model of the function blocks feeding the shift registers
module fb_model
	import shift_reg_pkg::*;
(
	// clock
	input wire logic hclk,
	// function inputs
	output logic [shift_reg_pkg::NUM_REGS-1:0] trg,
	output logic [shift_reg_pkg::NUM_REGS-1:0] din,
	output logic [shift_reg_pkg::NUM_REGS-1:0] dir
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		trg = 4'h0;
		din = 4'h0;
		dir = 4'h0;
	end
	// one trigger pulse, data and direction set with the rise
	task pulse(input int l, input logic d, input logic dr, input int hold);
		din[l] <= d;
		dir[l] <= dr;
		trg[l] <= 1'b1;
		repeat (hold) @(posedge hclk);
		trg[l] <= 1'b0;
		din[l] <= ~d;
		repeat (hold) @(posedge hclk);
	endtask : pulse
endmodule : fb_model

// ### tb/testbench.sv
// self-checking bench for the shift register block
module testbench
	import shift_reg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, rdph, hreadyout, hresp, d, dr;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [3:0] trg, din, dir, q;
	logic [7:0] sr [4];
	logic [31:0] exp_q [$];
	int err_total, n_tests, seed, l;
	shift_reg_block #(.SCAN_DIV(4), .RETAIN_DEFAULT(4'h2)) i_shift_reg_block (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .trg(trg), .din(din), .dir(dir), .q(q));
	fb_model i_fb_model (.hclk(hclk), .trg(trg), .din(din), .dir(dir));
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			err_total++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : check
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] dat);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= dat;
		rdph <= ~w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rdph <= 1'b0;
	endtask : xfer
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		xfer(1'b0, a, 32'h0000_0000);
	endtask : rd
	always @(posedge hclk)
	begin
		if (rdph && hreadyout && exp_q.size() > 0)
			check("read", hrdata, exp_q.pop_front());
	end
	initial
	begin
		seed = 32'h6360_a30e;
		{hsel, hwrite, rdph, haddr, hwdata, htrans} = '0;
		hresetn <= 1'b0;
		err_total = 0;
		n_tests = 0;
		for (int i = 0; i < 4; i++)
			sr[i] = 8'h00;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// retentive register powers up unknown: fill it, bus kept busy
		fork
			for (int i = 0; i < 8; i++)
				i_fb_model.pulse(1, 1'b1, 1'b0, 4);
			repeat (40)
				xfer(1'b1, CTRL_OFS, 32'h0000_0001);
		join
		sr[1] = 8'hff;
		rd(CONTENTS_OFS, {sr[3], sr[2], sr[1], sr[0]});
		for (int i = 0; i < 4; i++)
			rd(8'(i * 4), i == 1 ? 32'h0000_0100 : 32'h0000_0000);
		rd(CTRL_OFS, 32'h0000_0001);
		rd(8'h18, 32'h0000_0000);
		for (int i = 0; i < 24; i++)
		begin
			l = i % 4;
			d = 1'($random(seed));
			dr = 1'($random(seed));
			i_fb_model.pulse(l, d, dr, i % 3 == 0 ? 12 : 6);
			sr[l] = dr ? {d, sr[l][7:1]} : {sr[l][6:0], d};
			check("q", 32'(q[l]), 32'(sr[l][0]));
		end
		rd(CONTENTS_OFS, {sr[3], sr[2], sr[1], sr[0]});
		for (int s = 0; s < 8; s++)
		begin
			xfer(1'b1, CFG0_OFS, 32'(s));
			repeat (2) @(posedge hclk);
			check("q sel", 32'(q[0]), 32'(sr[0][s]));
		end
		xfer(1'b1, CFG0_OFS, 32'h0000_0000);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		sr[0] = 8'h00;
		sr[2] = 8'h00;
		sr[3] = 8'h00;
		repeat (3) @(posedge hclk);
		rd(CONTENTS_OFS, {sr[3], sr[2], sr[1], sr[0]});
		check("q kept", 32'(q[1]), 32'(sr[1][0]));
		complete_run();
	end
	initial
	begin
		repeat (20000) @(posedge hclk);
		err_total++;
		complete_run();
	end
endmodule : testbench
bind shift_reg_block shift_reg_checker i_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .trg(trg), .q(q));
